// ===== logic/orml_exec.sv
`timescale 1ns/100ps
`default_nettype none
`include "orml_consts.svh"

module orml_exec (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	output logic             instr_ack
);
	import orml_pkg::*;

	orml_state_t r;
	orml_state_t n;

	logic [`ORML_AW-1:0] gen_addr;
	logic                gen_indexed;
	logic [`ORML_AW-1:0] ram_raddr;
	logic [`ORML_DW-1:0] ram_rdata;
	logic                ram_we;
	logic [`ORML_AW-1:0] ram_waddr;
	logic [`ORML_DW-1:0] ram_wdata;
	logic                core_we;
	logic [`ORML_DW-1:0] alu_res;
	logic                apb_go;
	logic                apb_ram;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic orml_op_t decode(input logic [15:0] w);
		if (w[15:8] == `ORML_ENC_ORL) begin
			decode = orml_op_orl;
		end else if (w[15:10] == `ORML_ENC_ORWF) begin
			decode = orml_op_orwf;
		end else if (w[15:10] == `ORML_ENC_REGISTER_MOVE) begin
			decode = orml_op_register_move;
		end else if (w[15:8] == `ORML_ENC_PTR1 && w[7:6] == 2'b00) begin
			decode = orml_op_ptrh;
		end else begin
			decode = orml_op_none;
		end
	endfunction

	function automatic logic is_regop(input orml_op_t op);
		is_regop = (op == orml_op_orwf) || (op == orml_op_register_move);
	endfunction

	// ----------------------------------------
	// operand address and data memory
	// ----------------------------------------
	orml_addr_gen u_addr (
		.fld     (r.ir[7:0]),
		.acc_sel (r.ir[`ORML_A_BIT]),
		.bank    (r.bank),
		.ext     (r.ext),
		.base    (r.ptr[`ORML_PTR_IDX]),
		.addr    (gen_addr),
		.indexed (gen_indexed)
	);

	// software port only reads/writes in Q1/Q2, so the core owns Q2-Q4 traffic
	assign ram_raddr = (r.q == orml_q2) ? gen_addr : r.ram_addr;
	assign core_we   = (r.q == orml_q4) && is_regop(r.op) && r.ir[`ORML_D_BIT];
	assign ram_we    = core_we || (apb_go && pwrite && apb_ram);
	assign ram_waddr = core_we ? r.ea : r.ram_addr;
	assign ram_wdata = core_we ? alu_res : pwdata[7:0];

	orml_data_ram #(
		.AW (`ORML_AW),
		.DW (`ORML_DW)
	) u_ram (
		.clk     (pclk),
		.rd_addr (ram_raddr),
		.rd_data (ram_rdata),
		.wr_en   (ram_we),
		.wr_addr (ram_waddr),
		.wr_data (ram_wdata)
	);

	// ----------------------------------------
	// alu
	// ----------------------------------------
	always_comb begin
		case (r.op)
			orml_op_orl:  alu_res = r.acc | r.ir[7:0];
			orml_op_orwf: alu_res = r.acc | r.opnd;
			orml_op_register_move: alu_res = r.opnd;
			default:      alu_res = r.acc;
		endcase
	end

	assign apb_ram = (paddr == `ORML_OFF_RAM_DATA);
	assign apb_go  = psel && penable && !r.pready &&
		(!apb_ram || r.q == orml_q1 || r.q == orml_q2);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		n         = r;
		n.ack     = 1'b0;
		n.pready  = 1'b0;
		n.pslverr = 1'b0;

		// bus side first, so a core write in the same cycle wins
		if (apb_go) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			case (paddr)
				`ORML_OFF_CTRL: begin
					n.prdata[`ORML_CTRL_EXT] = r.ext;
					if (pwrite) n.ext = pwdata[`ORML_CTRL_EXT];
				end
				`ORML_OFF_ACC: begin
					n.prdata[7:0] = r.acc;
					if (pwrite) n.acc = pwdata[7:0];
				end
				`ORML_OFF_FLAGS: begin
					n.prdata[1:0] = r.flags;
					if (pwrite) n.flags = pwdata[1:0];
				end
				`ORML_OFF_BANK: begin
					n.prdata[`ORML_BANK_W-1:0] = r.bank;
					if (pwrite) n.bank = pwdata[`ORML_BANK_W-1:0];
				end
				`ORML_OFF_PTR0: begin
					n.prdata[`ORML_AW-1:0] = r.ptr[0];
					if (pwrite) n.ptr[0] = pwdata[`ORML_AW-1:0];
				end
				`ORML_OFF_PTR1: begin
					n.prdata[`ORML_AW-1:0] = r.ptr[1];
					if (pwrite) n.ptr[1] = pwdata[`ORML_AW-1:0];
				end
				`ORML_OFF_PTR2: begin
					n.prdata[`ORML_AW-1:0] = r.ptr[2];
					if (pwrite) n.ptr[2] = pwdata[`ORML_AW-1:0];
				end
				`ORML_OFF_RAM_ADDR: begin
					n.prdata[`ORML_AW-1:0] = r.ram_addr;
					if (pwrite) n.ram_addr = pwdata[`ORML_AW-1:0];
				end
				`ORML_OFF_RAM_DATA: begin
					n.prdata[7:0] = ram_rdata;
				end
				`ORML_OFF_STATUS: begin
					n.prdata[3:0] = {gen_indexed, r.pend, r.q};
				end
				default: begin
					n.pslverr = 1'b1;
				end
			endcase
		end

		case (r.q)
			orml_q1: begin
				n.q  = orml_q2;
				n.op = orml_op_none;
				if (instr_valid) begin
					n.ack = 1'b1;
					n.ir  = instr_word;
					if (r.pend) begin
						// a stray word in the second slot aborts the load
						n.op   = (instr_word[15:8] == `ORML_ENC_PTR2) ? orml_op_ptrl
							: orml_op_none;
						n.pend = 1'b0;
					end else begin
						n.op = decode(instr_word);
					end
				end
			end
			orml_q2: begin
				n.q  = orml_q3;
				n.ea = gen_addr;
			end
			orml_q3: begin
				n.q    = orml_q4;
				n.opnd = ram_rdata;
			end
			orml_q4: begin
				n.q = orml_q1;
				case (r.op)
					orml_op_orl, orml_op_orwf, orml_op_register_move: begin
						if (r.op == orml_op_orl || !r.ir[`ORML_D_BIT]) begin
							n.acc = alu_res;
						end
						n.flags[`ORML_FLAG_Z] = (alu_res == 8'h00);
						n.flags[`ORML_FLAG_N] = alu_res[7];
					end
					orml_op_ptrh: begin
						n.psel_ptr = r.ir[5:4];
						n.pend     = 1'b1;
						if (r.ir[5:4] < 2'(`ORML_NPTR)) begin
							n.ptr[r.ir[5:4]][11:8] = r.ir[3:0];
						end
					end
					orml_op_ptrl: begin
						if (r.psel_ptr < 2'(`ORML_NPTR)) begin
							n.ptr[r.psel_ptr][7:0] = r.ir[7:0];
						end
					end
					default: begin
					end
				endcase
			end
			default: begin
				n.q = orml_q1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign prdata    = r.prdata;
	assign pready    = r.pready;
	assign pslverr   = r.pslverr;
	assign instr_ack = r.ack;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic flag_wr;
	assign flag_wr = apb_go && pwrite && (paddr == `ORML_OFF_FLAGS);

	sequence s_word_phases;
		(r.q == orml_q2) ##1 (r.q == orml_q3) ##1 (r.q == orml_q4) ##1 (r.q == orml_q1);
	endsequence

	property p_phase;
		(r.q == orml_q1) |=> s_word_phases;
	endproperty
	a_phase: assert property (p_phase) else $error("phase order broken");

	property p_ack;
		(r.q == orml_q1 && instr_valid) |=> instr_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("instruction not acknowledged");

	property p_or_lit;
		(r.q == orml_q4 && r.op == orml_op_orl) |=>
			(r.acc == $past(r.acc | r.ir[7:0])) && (r.flags[`ORML_FLAG_N] == r.acc[7]) &&
			(r.flags[`ORML_FLAG_Z] == (r.acc == 8'h00));
	endproperty
	a_or_lit: assert property (p_or_lit) else $error("literal OR wrong");

	property p_or_reg;
		(r.q == orml_q4 && r.op == orml_op_orwf && !r.ir[`ORML_D_BIT]) |=>
			(r.acc == $past(r.acc | r.opnd)) && (r.flags[`ORML_FLAG_N] == r.acc[7]);
	endproperty
	a_or_reg: assert property (p_or_reg) else $error("register OR wrong");

	property p_dest;
		(r.q == orml_q4 && is_regop(r.op) && r.ir[`ORML_D_BIT]) |->
			ram_we && (ram_waddr == r.ea) &&
			(ram_wdata == ((r.op == orml_op_register_move) ? r.opnd : (r.acc | r.opnd)));
	endproperty
	a_dest: assert property (p_dest) else $error("write-back missing");

	property p_bank;
		(r.q == orml_q2 && is_regop(r.op) && r.ir[`ORML_A_BIT]) |->
			(ram_raddr == {r.bank, r.ir[7:0]});
	endproperty
	a_bank: assert property (p_bank) else $error("banked address wrong");

	property p_indexed;
		(r.q == orml_q2 && is_regop(r.op) && !r.ir[`ORML_A_BIT] && r.ext &&
			r.ir[7:0] <= `ORML_IDX_MAX) |->
			(ram_raddr == r.ptr[`ORML_PTR_IDX] + {4'h0, r.ir[7:0]});
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed address wrong");

	property p_move;
		(r.q == orml_q4 && r.op == orml_op_register_move && !r.ir[`ORML_D_BIT]) |=>
			(r.acc == $past(r.opnd)) && (r.flags[`ORML_FLAG_Z] == (r.acc == 8'h00));
	endproperty
	a_move: assert property (p_move) else $error("move result wrong");

	property p_ptr_flags;
		(r.q == orml_q4 && (r.op == orml_op_ptrh || r.op == orml_op_ptrl) && !flag_wr) |=>
			$stable(r.flags);
	endproperty
	a_ptr_flags: assert property (p_ptr_flags) else $error("pointer load touched flags");

	property p_ptr_high;
		(r.q == orml_q4 && r.op == orml_op_ptrh && r.ir[5:4] != 2'b11) |=>
			(r.ptr[$past(r.ir[5:4])][11:8] == $past(r.ir[3:0])) && r.pend;
	endproperty
	a_ptr_high: assert property (p_ptr_high) else $error("pointer high bits wrong");

	property p_ptr_low;
		(r.q == orml_q4 && r.op == orml_op_ptrl && r.psel_ptr != 2'b11) |=>
			(r.ptr[$past(r.psel_ptr)][7:0] == $past(r.ir[7:0])) && !r.pend;
	endproperty
	a_ptr_low: assert property (p_ptr_low) else $error("pointer low byte wrong");

endmodule

`default_nettype wire

// ===== include/orml_consts.svh
`ifndef ORML_CONSTS_SVH
`define ORML_CONSTS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define ORML_DW          8
`define ORML_AW          12
`define ORML_BANK_W      4
`define ORML_NPTR        3

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ORML_OFF_CTRL     12'h000
`define ORML_OFF_ACC      12'h004
`define ORML_OFF_FLAGS    12'h008
`define ORML_OFF_BANK     12'h00C
`define ORML_OFF_PTR0     12'h010
`define ORML_OFF_PTR1     12'h014
`define ORML_OFF_PTR2     12'h018
`define ORML_OFF_RAM_ADDR 12'h01C
`define ORML_OFF_RAM_DATA 12'h020
`define ORML_OFF_STATUS   12'h024

// ----------------------------------------
// fields and encodings
// ----------------------------------------
`define ORML_FLAG_Z      0
`define ORML_FLAG_N      1
`define ORML_CTRL_EXT    0
`define ORML_D_BIT       9
`define ORML_A_BIT       8
`define ORML_ENC_ORL     8'h09
`define ORML_ENC_ORWF    6'h04
`define ORML_ENC_REGISTER_MOVE    6'h14
`define ORML_ENC_PTR1    8'hEE
`define ORML_ENC_PTR2    8'hF0
`define ORML_IDX_MAX     8'h5F
`define ORML_ACC_SPLIT   8'h80
`define ORML_ACC_HI_BANK 4'hF
`define ORML_PTR_IDX     2

`endif

// ===== include/orml_pkg.sv
`include "orml_consts.svh"

package orml_pkg;

	typedef enum logic [1:0] {
		orml_q1 = 2'b00,
		orml_q2 = 2'b01,
		orml_q3 = 2'b11,
		orml_q4 = 2'b10
	} orml_phase_t;

	typedef enum logic [2:0] {
		orml_op_none = 3'h0,
		orml_op_orl  = 3'h1,
		orml_op_orwf = 3'h2,
		orml_op_register_move = 3'h3,
		orml_op_ptrh = 3'h4,
		orml_op_ptrl = 3'h5
	} orml_op_t;

	typedef struct packed {
		orml_phase_t                                q;
		orml_op_t                                   op;
		logic                                       pend;
		logic [15:0]                                ir;
		logic [1:0]                                 psel_ptr;
		logic [`ORML_DW-1:0]                        opnd;
		logic [`ORML_DW-1:0]                        acc;
		logic [1:0]                                 flags;
		logic [`ORML_BANK_W-1:0]                    bank;
		logic                                       ext;
		logic [`ORML_NPTR-1:0][`ORML_AW-1:0]        ptr;
		logic [`ORML_AW-1:0]                        ram_addr;
		logic [`ORML_AW-1:0]                        ea;
		logic                                       ack;
		logic                                       pready;
		logic                                       pslverr;
		logic [31:0]                                prdata;
	} orml_state_t;

endpackage

// ===== logic/orml_data_ram.sv
`timescale 1ns/100ps
`default_nettype none

module orml_data_ram #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data
);

	// no reset on the array: contents are undefined until written
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

endmodule

`default_nettype wire

// ===== logic/orml_addr_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "orml_consts.svh"

module orml_addr_gen (
	input  wire logic [7:0]              fld,
	input  wire logic                    acc_sel,
	input  wire logic [`ORML_BANK_W-1:0] bank,
	input  wire logic                    ext,
	input  wire logic [`ORML_AW-1:0]     base,
	output logic      [`ORML_AW-1:0]     addr,
	output logic                         indexed
);

	// ----------------------------------------
	// access bank split: low half bank 0, upper half top bank
	// ----------------------------------------
	function automatic logic [`ORML_AW-1:0] access_addr(input logic [7:0] f);
		if (f < `ORML_ACC_SPLIT) begin
			access_addr = {{(`ORML_BANK_W){1'b0}}, f};
		end else begin
			access_addr = {`ORML_ACC_HI_BANK, f};
		end
	endfunction

	always_comb begin
		indexed = ext && !acc_sel && (fld <= `ORML_IDX_MAX);
		if (acc_sel) begin
			addr = {bank, fld};
		end else if (indexed) begin
			addr = base + {{(`ORML_AW-8){1'b0}}, fld};
		end else begin
			addr = access_addr(fld);
		end
	end

endmodule

`default_nettype wire

// ===== testbench/orml_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// program memory model, valid/ack handshake
// ----------------------------------------
module orml_prog_mem (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        instr_ack,
	input  wire logic        stall,
	output logic      [15:0] instr_word,
	output logic             instr_valid
);
	logic [15:0] q[$];

	function automatic void push(input logic [15:0] w);
		q.push_back(w);
	endfunction

	// word held until ack; idle bus toggles so stale data is never reused
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_valid <= 1'b0;
			instr_word  <= 16'hA5A5;
		end else if (instr_valid && instr_ack) begin
			instr_valid <= 1'b0;
			instr_word  <= ~instr_word;
		end else if (!instr_valid && q.size() != 0 && !stall) begin
			instr_word  <= q.pop_front();
			instr_valid <= 1'b1;
		end else if (!instr_valid) begin
			instr_word  <= ~instr_word;
		end
	end
endmodule

`default_nettype wire

// ===== testbench/tb_or_move_pointer_load_exec.sv
`timescale 1ns/100ps
`default_nettype none
`include "orml_consts.svh"

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_or_move_pointer_load_exec;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] instr_word;
	logic        instr_valid;
	logic        instr_ack;
	logic        stall = 1'b0;
	logic [31:0] rdata;
	logic        rerr;
	logic [11:0] ks[3];
	int          fail_count = 0;
	int          cmp_count = 0;

	always #20 pclk = ~pclk;

	orml_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_word(instr_word), .instr_valid(instr_valid),
		.instr_ack(instr_ack));

	orml_prog_mem pm_u (.pclk(pclk), .presetn(presetn), .instr_ack(instr_ack),
		.stall(stall), .instr_word(instr_word), .instr_valid(instr_valid));

	// ----------------------------------------
	// bus and program helpers
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdata, e)
	endtask

	task automatic ram(input logic [11:0] a, input logic [7:0] d);
		wr(`ORML_OFF_RAM_ADDR, {20'h0, a});
		wr(`ORML_OFF_RAM_DATA, {24'h0, d});
	endtask

	task automatic ram_chk(input logic [11:0] a, input logic [7:0] e);
		wr(`ORML_OFF_RAM_ADDR, {20'h0, a});
		chk(`ORML_OFF_RAM_DATA, {24'h0, e});
	endtask

	// two idle edges in a row: a pop at the sampling edge shows valid one edge later
	task automatic settle();
		int n;
		int quiet;
		n = 0;
		quiet = 0;
		while (quiet < 2 && n < 100) begin
			@(posedge pclk);
			n++;
			if (pm_u.q.size() == 0 && instr_valid !== 1'b1)
				quiet++;
			else
				quiet = 0;
		end
		if (n >= 100) fail_count++;
		repeat (4) @(posedge pclk);
	endtask

	task automatic run(input logic [15:0] w);
		pm_u.push(w);
		settle();
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_or_lit();
		wr(`ORML_OFF_ACC, 32'h9A);
		pm_u.push(16'h0935);
		run(16'h0940);
		chk(`ORML_OFF_ACC, 32'hFF);
		chk(`ORML_OFF_FLAGS, 32'h2);
		wr(`ORML_OFF_ACC, 32'h0);
		run(16'h0900);
		chk(`ORML_OFF_FLAGS, 32'h1);
		$display("test or_lit done");
	endtask

	task automatic t_or_reg();
		wr(`ORML_OFF_BANK, 32'h3);
		ram(12'h3C0, 8'h13);
		ram(12'h390, 8'h21);
		ram(12'hF90, 8'h04);
		wr(`ORML_OFF_ACC, 32'h91);
		run(16'h13C0);
		ram_chk(12'h3C0, 8'h93);
		chk(`ORML_OFF_ACC, 32'h91);
		chk(`ORML_OFF_FLAGS, 32'h2);
		run(16'h1090);
		chk(`ORML_OFF_ACC, 32'h95);
		$display("test or_reg done");
	endtask

	task automatic t_idx();
		wr(`ORML_OFF_CTRL, 32'h1);
		wr(`ORML_OFF_PTR2, 32'h100);
		ram(12'h15F, 8'hAA);
		ram(12'h05F, 8'h11);
		ram(12'h060, 8'h40);
		ram(12'h160, 8'h08);
		wr(`ORML_OFF_ACC, 32'h0);
		run(16'h105F);
		chk(`ORML_OFF_ACC, 32'hAA);
		wr(`ORML_OFF_ACC, 32'h0);
		run(16'h1060);
		chk(`ORML_OFF_ACC, 32'h40);
		wr(`ORML_OFF_CTRL, 32'h0);
		$display("test idx done");
	endtask

	task automatic t_move();
		ram(12'h3C1, 8'h00);
		ram(12'h3C2, 8'h80);
		wr(`ORML_OFF_ACC, 32'h55);
		run(16'h51C1);
		chk(`ORML_OFF_ACC, 32'h0);
		chk(`ORML_OFF_FLAGS, 32'h1);
		run(16'h53C2);
		chk(`ORML_OFF_ACC, 32'h0);
		chk(`ORML_OFF_FLAGS, 32'h2);
		ram_chk(12'h3C2, 8'h80);
		$display("test move done");
	endtask

	task automatic t_ptr();
		ks[0] = 12'h000;
		ks[1] = 12'h3AB;
		ks[2] = 12'hFFF;
		for (int s = 0; s < 3; s++) begin
			pm_u.push(16'hEE00 | 16'(s << 4) | {12'h0, ks[s][11:8]});
			run({8'hF0, ks[s][7:0]});
			chk(`ORML_OFF_FLAGS, 32'h2);
		end
		for (int s = 0; s < 3; s++) begin
			chk(12'(`ORML_OFF_PTR0 + 4 * s), {20'h0, ks[s]});
		end
		wr(`ORML_OFF_PTR1, 32'h0);
		run(16'hEE15);
		stall <= 1'b1;
		@(posedge pclk);
		pm_u.push(16'hF0CD);
		repeat (8) @(posedge pclk);
		apb(1'b0, `ORML_OFF_STATUS, 32'h0);
		`CHK(rdata[2], 1'b1)
		chk(`ORML_OFF_PTR1, 32'h500);
		stall <= 1'b0;
		settle();
		chk(`ORML_OFF_PTR1, 32'h5CD);
		$display("test ptr done");
	endtask

	task automatic t_unmapped();
		apb(1'b1, 12'h028, 32'hFF);
		`CHK(rerr, 1'b1)
		apb(1'b0, 12'h028, 32'h0);
		`CHK(rdata, 32'h0)
		$display("test unmapped done");
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_or_lit();
		t_or_reg();
		t_idx();
		t_move();
		t_ptr();
		t_unmapped();
		tally_and_finish();
	end
endmodule

`default_nettype wire
